// file: rtl/trace_pkg.sv
/*
 * Package for the CAN error capture and live bit trace block: register
 * offsets, field positions, codes, carrier structs.
 * Assumes a 32-bit AHB-Lite register bus and one 25 MHz clock.
 */

package trace_pkg;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam logic [7:0] FAULT_CAPTURE_IDX = 8'h78;
    localparam logic [7:0] LIVE_BIT_TRACE_IDX = 8'h7A;
    localparam logic [9:0] FAULT_CAPTURE_ADDR = {FAULT_CAPTURE_IDX, 2'b00};
    localparam logic [9:0] LIVE_BIT_TRACE_ADDR = {LIVE_BIT_TRACE_IDX, 2'b00};
    localparam logic [9:0] IRQ_STATUS_ADDR = 10'h200;
    localparam logic [9:0] IRQ_ENABLE_ADDR = 10'h204;
    localparam logic [9:0] IRQ_CLEAR_ADDR = 10'h208;
    localparam logic [15:0] FAULT_CAPTURE_RST = 16'h0000;
    localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int ERR_CODE_LSB = 13;
    localparam int SEG_LSB = 8;
    localparam int CAP_TX_BIT = 7;
    localparam int CAP_RX_BIT = 6;
    localparam int TRC_STUFF_BIT = 15;
    localparam int TRC_RXLINE_BIT = 14;
    localparam int TRC_TXLINE_BIT = 13;
    localparam int TRC_RX_BIT = 7;
    localparam int TRC_TX_BIT = 6;
    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_BIT_BIT = 1;

    // ***************************************************************
    // Codes
    // ***************************************************************
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_CRC = 3'h1;
    localparam logic [2:0] ERR_FORM = 3'h2;
    localparam logic [2:0] ERR_ACK = 3'h3;
    localparam logic [2:0] ERR_STUFF = 3'h4;
    localparam logic [2:0] ERR_BIT = 3'h5;

    localparam logic [4:0] SEG_STOPPED = 5'h00;
    localparam logic [4:0] SEG_SYNC = 5'h01;
    localparam logic [4:0] SEG_INTERFRAME = 5'h05;
    localparam logic [4:0] SEG_BUS_IDLE = 5'h06;
    localparam logic [4:0] SEG_SOF = 5'h07;
    localparam logic [4:0] SEG_ARB = 5'h08;
    localparam logic [4:0] SEG_CONTROL = 5'h09;
    localparam logic [4:0] SEG_DATA = 5'h0A;
    localparam logic [4:0] SEG_CRC = 5'h0B;
    localparam logic [4:0] SEG_ACK = 5'h0C;
    localparam logic [4:0] SEG_EOF = 5'h0D;
    localparam logic [4:0] SEG_ERR_FLAG = 5'h10;
    localparam logic [4:0] SEG_ERR_ECHO = 5'h11;
    localparam logic [4:0] SEG_ERR_DELIM = 5'h12;
    localparam logic [4:0] SEG_OVL_FLAG = 5'h18;
    localparam logic [4:0] SEG_OVL_ECHO = 5'h19;
    localparam logic [4:0] SEG_OVL_DELIM = 5'h1A;

    // ***************************************************************
    // Carriers
    // ***************************************************************
    typedef struct packed {
        logic bit_tick;
        logic [4:0] segment_code;
        logic [5:0] segment_bit_index;
        logic sending_flag;
        logic receiving_flag;
        logic padding_bit_flag;
        logic rx_line;
        logic tx_line;
    } frame_state_s;

    typedef struct packed {
        logic valid;
        logic [2:0] code;
    } bus_error_s;

    typedef enum logic {
        PH_IDLE,
        PH_DATA
    } bus_phase_e;

endpackage

// file: rtl/can_error_and_bit_trace_capture.sv
/*
 * CAN error capture and live bit trace register block with AHB-Lite
 * slave and level interrupt.
 * Assumes the protocol engine supplies its frame state with a one-cycle
 * tick per nominal bit time, and an error pulse, all on CLK_IN.
 */
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module can_error_and_bit_trace_capture
    import trace_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire frame_state_s FRAME_IN,
    input wire bus_error_s ERROR_IN,
    output var logic [31:0] HRDATA_OUT,
    output var logic HREADYOUT_OUT,
    output var logic HRESP_OUT,
    output var logic IRQ_OUT
);

    // ***************************************************************
    // Helpers
    // ***************************************************************
    // Undefined codes are forced to the stopped code so none leaks out
    function automatic logic [4:0] legal_seg(input logic [4:0] s);
        logic [4:0] r;
        r = SEG_STOPPED;
        case (s)
            SEG_STOPPED, SEG_SYNC, SEG_INTERFRAME, SEG_BUS_IDLE: r = s;
            SEG_SOF, SEG_ARB, SEG_CONTROL, SEG_DATA, SEG_CRC, SEG_ACK, SEG_EOF: r = s;
            SEG_ERR_FLAG, SEG_ERR_ECHO, SEG_ERR_DELIM, SEG_OVL_FLAG: r = s;
            SEG_OVL_ECHO, SEG_OVL_DELIM: r = s;
            default: r = SEG_STOPPED;
        endcase
        return r;
    endfunction

    function automatic logic [2:0] legal_err(input logic [2:0] e);
        return (e > ERR_BIT) ? ERR_NONE : e;
    endfunction

    // ***************************************************************
    // Capture and trace
    // ***************************************************************
    logic [15:0] capture_q, capture_d;
    logic [15:0] trace_q, trace_d;
    logic [1:0] status_q, status_d;
    logic [1:0] enable_q, enable_d;

    // Bus write strobes, decoded in the data phase
    logic wr_capture, wr_trace, wr_enable, wr_clear;
    logic [31:0] wdata;

    assign wdata = HWDATA_IN;

    always_comb begin
        capture_d = capture_q;
        if (wr_capture) begin
            capture_d = wdata[15:0];
        end
        if (ERROR_IN.valid) begin
            capture_d = '0;
            capture_d[ERR_CODE_LSB +: 3] = legal_err(ERROR_IN.code);
            capture_d[SEG_LSB +: 5] = legal_seg(FRAME_IN.segment_code);
            capture_d[CAP_TX_BIT] = FRAME_IN.sending_flag;
            capture_d[CAP_RX_BIT] = FRAME_IN.receiving_flag & ~FRAME_IN.sending_flag;
            capture_d[5:0] = FRAME_IN.segment_bit_index;
        end
    end

    always_comb begin
        trace_d = trace_q;
        if (wr_trace) begin
            trace_d = wdata[15:0];
        end
        if (FRAME_IN.bit_tick) begin
            trace_d[TRC_STUFF_BIT] = FRAME_IN.padding_bit_flag;
            trace_d[TRC_RXLINE_BIT] = FRAME_IN.rx_line;
            trace_d[TRC_TXLINE_BIT] = FRAME_IN.tx_line;
            trace_d[SEG_LSB +: 5] = legal_seg(FRAME_IN.segment_code);
            trace_d[TRC_RX_BIT] = FRAME_IN.receiving_flag & ~FRAME_IN.sending_flag;
            trace_d[TRC_TX_BIT] = FRAME_IN.sending_flag;
            trace_d[5:0] = FRAME_IN.segment_bit_index;
        end
    end

    // Sticky events: set wins over a clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (wr_clear) begin
            status_d = status_q & ~wdata[1:0];
        end
        if (ERROR_IN.valid) begin
            status_d[IRQ_ERR_BIT] = 1'b1;
        end
        if (FRAME_IN.bit_tick) begin
            status_d[IRQ_BIT_BIT] = 1'b1;
        end
        enable_d = wr_enable ? wdata[1:0] : enable_q;
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            capture_q <= FAULT_CAPTURE_RST;
            status_q <= 2'h0;
            enable_q <= IRQ_ENABLE_RST;
        end else begin
            capture_q <= capture_d;
            status_q <= status_d;
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge CLK_IN) begin
        trace_q <= trace_d;
    end

    // ***************************************************************
    // AHB-Lite slave
    // ***************************************************************
    // Zero wait states: reads use the next-state value at the address
    // phase edge, so a read sees the value from a same-cycle update.
    bus_phase_e phase_q, phase_d;
    logic write_q, write_d;
    logic [9:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic take;

    assign take = HSEL_IN & HREADY_IN & HTRANS_IN[1];

    always_comb begin
        phase_d = take ? PH_DATA : PH_IDLE;
        write_d = take & HWRITE_IN;
        addr_d = take ? HADDR_IN[9:0] : addr_q;
    end

    always_comb begin
        wr_capture = (phase_q == PH_DATA) & write_q & (addr_q == FAULT_CAPTURE_ADDR);
        wr_trace = (phase_q == PH_DATA) & write_q & (addr_q == LIVE_BIT_TRACE_ADDR);
        wr_enable = (phase_q == PH_DATA) & write_q & (addr_q == IRQ_ENABLE_ADDR);
        wr_clear = (phase_q == PH_DATA) & write_q & (addr_q == IRQ_CLEAR_ADDR);
    end

    // Read data is registered from the address phase; unmapped reads zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (take && !HWRITE_IN) begin
            case (HADDR_IN[9:0])
                FAULT_CAPTURE_ADDR: rdata_d = {16'h0000, capture_d};
                LIVE_BIT_TRACE_ADDR: rdata_d = {16'h0000, trace_d};
                IRQ_STATUS_ADDR: rdata_d = {30'h0000_0000, status_d};
                IRQ_ENABLE_ADDR: rdata_d = {30'h0000_0000, enable_d};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        irq_d = |(status_d & enable_d);
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            phase_q <= PH_IDLE;
            write_q <= 1'b0;
            addr_q <= 10'h000;
            rdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            write_q <= write_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end
    end

    assign HRDATA_OUT = rdata_q;
    assign IRQ_OUT = irq_q;

endmodule

`default_nettype wire

// file: test/trace_checker_properties.sv
/* Checker for the capture block, watching top-level ports only.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module trace_checker
    import trace_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire frame_state_s FRAME_IN,
    input wire bus_error_s ERROR_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT
);
    logic rd, cap, trc, rd_d, rd_q, seg_ok;
    logic [4:0] seg_exp;
    frame_state_s fq_d, fq_q;
    // Undefined segment codes read back as the stopped code
    assign seg_ok = fq_q.segment_code inside {SEG_STOPPED, SEG_SYNC, SEG_INTERFRAME,
        SEG_BUS_IDLE, SEG_SOF, SEG_ARB, SEG_CONTROL, SEG_DATA, SEG_CRC, SEG_ACK, SEG_EOF,
        SEG_ERR_FLAG, SEG_ERR_ECHO, SEG_ERR_DELIM, SEG_OVL_FLAG, SEG_OVL_ECHO, SEG_OVL_DELIM};
    assign seg_exp = seg_ok ? fq_q.segment_code : SEG_STOPPED;
    assign rd = HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN;
    assign cap = rd && HADDR_IN[9:0] == FAULT_CAPTURE_ADDR && ERROR_IN.valid;
    assign trc = rd && HADDR_IN[9:0] == LIVE_BIT_TRACE_ADDR && FRAME_IN.bit_tick;
    always_comb begin
        rd_d = RST_N_IN && rd;
        fq_d = FRAME_IN;
    end
    always_ff @(posedge CLK_IN) begin
        rd_q <= rd_d;
        fq_q <= fq_d;
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    AST_OKAY: assert property (HREADYOUT_OUT && !HRESP_OUT)
        else $error("slave not ready or not okay");
    AST_CODE: assert property (cap && ERROR_IN.code <= ERR_BIT |=>
        HRDATA_OUT[15:13] == $past(ERROR_IN.code)) else $error("capture code wrong");
    AST_SEG: assert property (cap |=> HRDATA_OUT[12:8] == seg_exp)
        else $error("capture segment wrong");
    AST_TX: assert property (cap |=> HRDATA_OUT[7] == fq_q.sending_flag)
        else $error("capture send flag wrong");
    AST_RX: assert property (cap |=> HRDATA_OUT[6] ==
        (fq_q.receiving_flag && !fq_q.sending_flag)) else $error("capture receive flag wrong");
    AST_IDX: assert property (cap |=> HRDATA_OUT[5:0] == fq_q.segment_bit_index)
        else $error("capture index wrong");
    AST_TRACE: assert property (trc |=> HRDATA_OUT[15:0] == {fq_q.padding_bit_flag,
        fq_q.rx_line, fq_q.tx_line, seg_exp, fq_q.receiving_flag && !fq_q.sending_flag,
        fq_q.sending_flag, fq_q.segment_bit_index}) else $error("trace value wrong");
    AST_IDLE: assert property (!rd_q |-> HRDATA_OUT == 32'h0)
        else $error("read data not zero between reads");
    cover property (cap);
    cover property (trc);
    cover property (rd_q && HRDATA_OUT[15:13] == ERR_BIT);
endmodule
bind can_error_and_bit_trace_capture trace_checker CHK (.CLK_IN, .RST_N_IN, .HSEL_IN,
    .HADDR_IN, .HTRANS_IN, .HWRITE_IN, .HREADY_IN, .FRAME_IN, .ERROR_IN, .HRDATA_OUT,
    .HREADYOUT_OUT, .HRESP_OUT);
`default_nettype wire

// file: test/can_engine_model.sv
/* Protocol engine stand-in: frame state levels, bit ticks, error pulses.
   Assumes its tasks are called just after a rising CLK_IN edge. */
`timescale 1ns/100ps
`default_nettype none
module can_engine_model
    import trace_pkg::*;
(
    input wire logic CLK_IN,
    output frame_state_s FRAME_OUT,
    output bus_error_s ERROR_OUT
);
    initial begin
        FRAME_OUT = '0;
        ERROR_OUT = '0;
    end
    // one tick per bit; cyc sets the bit length, so slow and prompt
    task automatic send_bit(input frame_state_s f, input int cyc);
        @(posedge CLK_IN);
        FRAME_OUT <= f;
        repeat (cyc) @(posedge CLK_IN);
        FRAME_OUT.bit_tick <= 1'b1;
        @(posedge CLK_IN);
        FRAME_OUT.bit_tick <= 1'b0;
    endtask
    task automatic raise_error(input logic [2:0] code);
        @(posedge CLK_IN);
        ERROR_OUT <= '{1'b1, code};
        @(posedge CLK_IN);
        ERROR_OUT.valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
/* Self-checking bench for the capture block.
   Assumes the engine model on the frame side and one AHB-Lite master. */
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import trace_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic ready, hresp, irq;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    frame_state_s frame, f;
    bus_error_s err;
    int miscompares = 0;
    int comparisons = 0;
    logic [4:0] segs [17] = '{5'h00, 5'h01, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A,
        5'h0B, 5'h0C, 5'h0D, 5'h10, 5'h11, 5'h12, 5'h18, 5'h19, 5'h1A};
    can_error_and_bit_trace_capture DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(ready), .FRAME_IN(frame), .ERROR_IN(err),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(ready), .HRESP_OUT(hresp), .IRQ_OUT(irq));
    can_engine_model ENG (.CLK_IN(clk), .FRAME_OUT(frame), .ERROR_OUT(err));
    initial forever #20 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Entered just after an edge; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        haddr <= {22'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic test_reset;
        bus(0, FAULT_CAPTURE_ADDR, 0);
        chk("capture", 32'h0, rd);
        bus(0, LIVE_BIT_TRACE_ADDR, 0);
        chk("trace", 32'h0000XXXX, rd);
        bus(0, 10'h3FC, 0);
        chk("unmapped", 32'h0, rd);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test_reset done");
    endtask
    task automatic test_capture;
        for (int i = 0; i < 5; i++) begin
            f = '{1'b0, segs[i * 4], 6'(i * 15 + i / 4 * 3), i[0], !i[0] && i < 4, 1'b0,
                1'b1, 1'b0};
            ENG.send_bit(f, 1);
            fork
                ENG.raise_error(3'(i + 1));
                begin
                    @(posedge clk);
                    bus(0, FAULT_CAPTURE_ADDR, 0);
                end
            join
            chk("capture", {16'h0, 3'(i + 1), f.segment_code, f.sending_flag,
                f.receiving_flag, f.segment_bit_index}, rd);
        end
        $display("test_capture done");
    endtask
    task automatic test_trace;
        for (int i = 0; i < 17; i++) begin
            f = '{1'b0, segs[i], 6'(63 - 3 * i), i[1], !i[1], i[0], i[1], i[2]};
            fork
                ENG.send_bit(f, i + 1);
                begin
                    repeat (i + 2) @(posedge clk);
                    bus(0, LIVE_BIT_TRACE_ADDR, 0);
                end
            join
            chk("trace", {16'h0, i[0], i[1], i[2], segs[i], !i[1], i[1],
                6'(63 - 3 * i)}, rd);
        end
        $display("test_trace done");
    endtask
    task automatic test_refused;
        f = '{1'b0, 5'h1F, 6'h2A, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        ENG.send_bit(f, 1);
        bus(0, LIVE_BIT_TRACE_ADDR, 0);
        chk("trace undefined seg", {16'h0, 3'h1, SEG_STOPPED, 2'h1, 6'h2A}, rd);
        fork
            ENG.raise_error(3'h7);
            begin
                @(posedge clk);
                bus(0, FAULT_CAPTURE_ADDR, 0);
            end
        join
        chk("capture undefined", {16'h0, ERR_NONE, SEG_STOPPED, 2'h2, 6'h2A}, rd);
        $display("test_refused done");
    endtask
    task automatic test_irq;
        bus(0, IRQ_STATUS_ADDR, 0);
        chk("status", 32'h3, rd);
        bus(1, IRQ_CLEAR_ADDR, 32'h3);
        bus(1, IRQ_ENABLE_ADDR, 32'h1);
        ENG.send_bit(f, 2);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        ENG.raise_error(ERR_STUFF);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1, IRQ_CLEAR_ADDR, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(0, IRQ_STATUS_ADDR, 0);
        chk("status", 32'h2, rd);
        $display("test_irq done");
    endtask
    task automatic test_regs;
        bus(1, FAULT_CAPTURE_ADDR, 32'hA55A);
        bus(1, LIVE_BIT_TRACE_ADDR, 32'h5AA5);
        bus(1, 10'h3FC, 32'hFFFF);
        bus(0, FAULT_CAPTURE_ADDR, 0);
        chk("capture", 32'hA55A, rd);
        bus(0, LIVE_BIT_TRACE_ADDR, 0);
        chk("trace", 32'h5AA5, rd);
        bus(0, 10'h3FC, 0);
        chk("unmapped", 32'h0, rd);
        $display("test_regs done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_reset;
        test_capture;
        test_trace;
        test_refused;
        test_irq;
        test_regs;
        end_of_test;
    end
    // Whole run is under a thousand cycles; five thousand means a hang
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test;
    end
endmodule
`default_nettype wire
